/* shared/act_pkg.sv */
// constants, register map and types of the actuator status and watchdog block
// assumes a 100 MHz clock; long counts are re-exposed as top-level parameters
package act_pkg;

	// word carried by every register access
	typedef logic [15:0] reg_word_t;
	typedef logic [4:0]  node_addr_t;

	// clock rate and documented times
	localparam longint unsigned CLK_HZ          = 100_000_000;
	localparam longint unsigned WDOG_TIMEOUT_S  = 120;
	localparam longint unsigned ADDR_HOLD_MS    = 3000;
	localparam longint unsigned FACT_HOLD_MS    = 5000;
	localparam longint unsigned FLASH_STEP_MS   = 250;
	localparam longint unsigned FLICKER_STEP_MS = 50;
	localparam longint unsigned BUS_ACTIVE_MS   = 200;

	// cycle counts derived from the times, and the fixed pin settle count
	localparam logic [39:0] WDOG_CYCLES    = 40'(WDOG_TIMEOUT_S * CLK_HZ);
	localparam logic [31:0] ADDR_HOLD_CYC  = 32'(ADDR_HOLD_MS * (CLK_HZ / 1000));
	localparam logic [31:0] FACT_HOLD_CYC  = 32'(FACT_HOLD_MS * (CLK_HZ / 1000));
	localparam logic [31:0] FLASH_CYC      = 32'(FLASH_STEP_MS * (CLK_HZ / 1000));
	localparam logic [31:0] FLICKER_CYC    = 32'(FLICKER_STEP_MS * (CLK_HZ / 1000));
	localparam logic [31:0] BUS_ACTIVE_CYC = 32'(BUS_ACTIVE_MS * (CLK_HZ / 1000));
	localparam logic [1:0]  PIN_SETTLE_CYC = 2'h3;

	// register offsets
	localparam reg_word_t REG_SETPOINT = 16'h0001;
	localparam reg_word_t REG_OVERRIDE = 16'h0002;
	localparam reg_word_t REG_COMMAND  = 16'h0003;
	localparam reg_word_t REG_STATUS   = 16'h0069;
	localparam reg_word_t REG_MIN_LIM  = 16'h006A;
	localparam reg_word_t REG_MAX_LIM  = 16'h006B;
	localparam reg_word_t REG_SENSOR   = 16'h006C;
	localparam reg_word_t REG_BUSFAIL  = 16'h006D;

	// command and value ranges
	localparam reg_word_t CMD_CLEAR_FAULTS = 16'h0004;
	localparam reg_word_t LIMIT_FULL       = 16'h2710;
	localparam reg_word_t MAX_LIM_LOW      = 16'h07D0;
	localparam reg_word_t SENSOR_LAST      = 16'h0004;
	localparam reg_word_t BUSFAIL_HOLD     = 16'h0000;
	localparam reg_word_t BUSFAIL_CLOSE    = 16'h0001;
	localparam reg_word_t BUSFAIL_OPEN     = 16'h0002;

	// values after reset and the node address range
	localparam reg_word_t MIN_LIM_RST = 16'h0000;
	localparam reg_word_t MAX_LIM_RST = 16'h2710;
	localparam reg_word_t SENSOR_RST  = 16'h0000;
	localparam reg_word_t BUSFAIL_RST = 16'h0000;
	localparam node_addr_t ADDR_FIRST = 5'h01;
	localparam node_addr_t ADDR_LAST  = 5'h10;
	localparam node_addr_t ADDR_RST   = 5'h01;

	// status word bit positions
	localparam int BIT_UTILISATION = 0;
	localparam int BIT_SAFETY      = 4;
	localparam int BIT_ACTIVITY    = 8;
	localparam int BIT_GEAR        = 9;
	localparam int BIT_WATCHDOG    = 10;
	localparam logic [7:0] FAULT_USED_MASK = 8'hF7;
	localparam logic [7:0] FAULT_CLR_MASK  = 8'hEE;

endpackage : act_pkg

/* shared/btn_if.sv */
// events of one synchronised push-button passed from the button timer to the top
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface btn_if;
	logic level;
	logic press;
	logic release_evt;
	logic hold_a;
	logic hold_b;
	modport src (output level, output press, output release_evt, output hold_a, output hold_b);
	modport dst (input level, input press, input release_evt, input hold_a, input hold_b);
endinterface : btn_if

/* design/button_timer.sv */
// synchronises one push-button pin and times how long it is held
// assumes an asynchronous pin, active high when pressed
`timescale 1ns/1ps
module button_timer #(
	parameter logic [31:0] HOLD_A = 32'h0000_0010,
	parameter logic [31:0] HOLD_B = 32'h0000_0020
) (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// button pin
	input  wire logic i_pin,
	// timed events
	btn_if.src        btn
);

	typedef struct packed {
		logic        s1;
		logic        s2;
		logic        lvl;
		logic [31:0] cnt;
		logic        press;
		logic        rel;
		logic        ha;
		logic        hb;
	} btn_state_t;

	btn_state_t st_r;
	btn_state_t st_nxt;

	// edge detection and hold counting, one-cycle event pulses
	always_comb begin
		st_nxt       = st_r;
		st_nxt.s1    = i_pin;
		st_nxt.s2    = st_r.s1;
		st_nxt.lvl   = st_r.s2;
		st_nxt.press = st_r.s2 & ~st_r.lvl;
		st_nxt.rel   = ~st_r.s2 & st_r.lvl;
		st_nxt.ha    = 1'b0;
		st_nxt.hb    = 1'b0;
		if (!st_r.s2) begin
			st_nxt.cnt = 32'h0000_0000;
		end else if (st_r.cnt != 32'hFFFF_FFFF) begin
			st_nxt.cnt = st_r.cnt + 32'h0000_0001;
			st_nxt.ha  = (st_r.cnt == HOLD_A); // held strictly longer than A
			st_nxt.hb  = (st_r.cnt == HOLD_B);
		end
	end

	// state register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign btn.level       = st_r.lvl;
	assign btn.press       = st_r.press;
	assign btn.release_evt = st_r.rel;
	assign btn.hold_a      = st_r.ha;
	assign btn.hold_b      = st_r.hb;

endmodule : button_timer

/* design/actuator_status_and_bus_watchdog.sv */
// status word, limit and sensor settings, bus watchdog and local buttons and lamps of a damper actuator
// assumes register accesses arrive already decoded from the field bus, on the same clock
`timescale 1ns/1ps
module actuator_status_and_bus_watchdog #(
	parameter logic [39:0] WDOG_TIMEOUT   = act_pkg::WDOG_CYCLES,
	parameter logic [31:0] ADDR_HOLD      = act_pkg::ADDR_HOLD_CYC,
	parameter logic [31:0] FACT_HOLD      = act_pkg::FACT_HOLD_CYC,
	parameter logic [31:0] FLASH_STEP     = act_pkg::FLASH_CYC,
	parameter logic [31:0] FLICKER_STEP   = act_pkg::FLICKER_CYC,
	parameter logic [31:0] BUS_ACTIVE     = act_pkg::BUS_ACTIVE_CYC
) (
	// clock and reset
	input  wire logic                i_clk,
	input  wire logic                i_rst,
	// decoded register access
	input  wire logic                i_reg_wr,
	input  wire logic                i_reg_rd,
	input  wire act_pkg::reg_word_t  i_reg_addr,
	input  wire act_pkg::reg_word_t  i_reg_wdata,
	output logic                     o_reg_ack,
	output act_pkg::reg_word_t       o_reg_rdata,
	// actuator fault events and motion handshake
	input  wire logic [7:0]          i_fault_evt,
	input  wire logic                i_motion_done,
	// local controls (pins)
	input  wire logic                i_btn_yellow,
	input  wire logic                i_btn_green,
	input  wire logic                i_btn_gear,
	input  wire logic                i_dir_switch,
	// settings towards the positioner
	output act_pkg::reg_word_t       o_min_limit,
	output act_pkg::reg_word_t       o_max_limit,
	output logic [2:0]               o_sensor_type,
	output act_pkg::node_addr_t      o_node_addr,
	output logic                     o_factory_reset,
	// motion control
	output logic                     o_fail_close,
	output logic                     o_fail_open,
	output logic                     o_motor_stop,
	output logic                     o_adapt_run,
	output logic                     o_sync_run,
	output logic                     o_dir_reverse,
	// lamps
	output logic                     o_led_green,
	output logic                     o_led_yellow
);
	import act_pkg::*;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_ADDR,
		ST_ADAPT,
		ST_GEAR,
		ST_SYNC
	} mode_t;

	typedef struct packed {
		mode_t       mode;
		logic [7:0]  faults;
		logic        wd_flag;
		reg_word_t   min_lim;
		reg_word_t   max_lim;
		logic [2:0]  sensor;
		reg_word_t   busfail;
		logic [39:0] wd_cnt;
		logic        fail_close;
		logic        fail_open;
		node_addr_t  addr_sel;
		node_addr_t  node_addr;
		logic        startup;
		logic [1:0]  settle;
		logic        factory;
		logic        dir_s1;
		logic        dir_s2;
		logic        ack;
		reg_word_t   rdata;
		logic [31:0] flash_tmr;
		logic [5:0]  flash_ph;
		logic [31:0] bus_tmr;
		logic [31:0] flick_tmr;
		logic        flick_on;
		logic        led_green;
		logic        led_yellow;
		logic [2:0]  run_flags;
	} top_state_t;

	top_state_t st_r;
	top_state_t st_nxt;

	btn_if yel ();
	btn_if grn ();
	btn_if gear ();

	// yellow button times both the address-mode and the factory-reset holds
	button_timer #(
		.HOLD_A (ADDR_HOLD),
		.HOLD_B (FACT_HOLD)
	) u_yellow (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_pin (i_btn_yellow),
		.btn   (yel)
	);

	// green button, only short presses matter
	button_timer #(
		.HOLD_A (ADDR_HOLD),
		.HOLD_B (FACT_HOLD)
	) u_green (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_pin (i_btn_green),
		.btn   (grn)
	);

	// gear disengagement button, used as a level and for its release event
	button_timer #(
		.HOLD_A (ADDR_HOLD),
		.HOLD_B (FACT_HOLD)
	) u_gear (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_pin (i_btn_gear),
		.btn   (gear)
	);

	// true when a written value lies inside an inclusive range
	function automatic logic in_range(input reg_word_t v, input reg_word_t lo, input reg_word_t hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	// true for a register this block answers for
	function automatic logic is_local(input reg_word_t a);
		is_local = in_range(a, REG_STATUS, REG_BUSFAIL);
	endfunction : is_local

	logic [15:0] status_word;
	logic        wr_local;
	logic        clr_cmd;
	logic        wd_kick;

	// assembled status word and decoded write strobes
	always_comb begin
		status_word                = 16'h0000;
		status_word[7:0]           = st_r.faults & FAULT_USED_MASK;
		status_word[BIT_ACTIVITY]  = (st_r.mode == ST_ADAPT) || (st_r.mode == ST_SYNC);
		status_word[BIT_GEAR]      = (st_r.mode == ST_GEAR);
		status_word[BIT_WATCHDOG]  = st_r.wd_flag;
		wr_local = i_reg_wr && is_local(i_reg_addr);
		clr_cmd  = i_reg_wr && (i_reg_addr == REG_COMMAND) && (i_reg_wdata == CMD_CLEAR_FAULTS);
		wd_kick  = i_reg_wr && ((i_reg_addr == REG_SETPOINT) || (i_reg_addr == REG_OVERRIDE));
	end

	// next-state logic of the whole block
	always_comb begin
		st_nxt         = st_r;
		st_nxt.factory = 1'b0;

		// register answers, one cycle after the strobe
		st_nxt.ack = (i_reg_rd && is_local(i_reg_addr)) || wr_local ||
			(i_reg_wr && (i_reg_addr == REG_COMMAND));
		if (i_reg_rd) begin
			case (i_reg_addr)
				REG_STATUS:  st_nxt.rdata = status_word;
				REG_MIN_LIM: st_nxt.rdata = st_r.min_lim;
				REG_MAX_LIM: st_nxt.rdata = st_r.max_lim;
				REG_SENSOR:  st_nxt.rdata = {13'h0000, st_r.sensor};
				REG_BUSFAIL: st_nxt.rdata = st_r.busfail;
				default:     st_nxt.rdata = 16'h0000;
			endcase
		end

		// settings; values outside their range are ignored
		if (wr_local) begin
			case (i_reg_addr)
				REG_MIN_LIM: if (in_range(i_reg_wdata, 16'h0000, LIMIT_FULL)) st_nxt.min_lim = i_reg_wdata;
				REG_MAX_LIM: if (in_range(i_reg_wdata, MAX_LIM_LOW, LIMIT_FULL)) st_nxt.max_lim = i_reg_wdata;
				REG_SENSOR:  if (in_range(i_reg_wdata, 16'h0000, SENSOR_LAST)) st_nxt.sensor = i_reg_wdata[2:0];
				REG_BUSFAIL: if (in_range(i_reg_wdata, BUSFAIL_HOLD, BUSFAIL_OPEN)) st_nxt.busfail = i_reg_wdata;
				default:     st_nxt.rdata = st_r.rdata; // status is read only
			endcase
		end

		// sticky faults: a new event wins over a clear in the same cycle
		if (clr_cmd) begin
			st_nxt.faults = st_r.faults & ~FAULT_CLR_MASK;
		end
		st_nxt.faults = st_nxt.faults | (i_fault_evt & FAULT_USED_MASK);

		// bus watchdog
		if (st_r.busfail == BUSFAIL_HOLD) begin
			st_nxt.wd_cnt     = 40'h00_0000_0000;
			st_nxt.fail_close = 1'b0;
			st_nxt.fail_open  = 1'b0;
		end else if (wd_kick) begin
			st_nxt.wd_cnt     = 40'h00_0000_0000;
			st_nxt.fail_close = 1'b0;
			st_nxt.fail_open  = 1'b0;
		end else if (st_r.wd_cnt == WDOG_TIMEOUT - 40'h00_0000_0001) begin
			st_nxt.wd_cnt     = WDOG_TIMEOUT;
			st_nxt.fail_close = (st_r.busfail == BUSFAIL_CLOSE);
			st_nxt.fail_open  = (st_r.busfail == BUSFAIL_OPEN);
		end else if (st_r.wd_cnt != WDOG_TIMEOUT) begin
			st_nxt.wd_cnt = st_r.wd_cnt + 40'h00_0000_0001;
		end
		if (clr_cmd) begin
			st_nxt.wd_flag = 1'b0;
		end
		if ((st_r.busfail != BUSFAIL_HOLD) && !wd_kick && (st_r.wd_cnt == WDOG_TIMEOUT - 40'h00_0000_0001)) begin
			st_nxt.wd_flag = 1'b1;
		end

		// start-up window for the factory reset hold
		if (st_r.settle != PIN_SETTLE_CYC) begin
			st_nxt.settle = st_r.settle + 2'h1;
		end else if (!yel.level) begin
			st_nxt.startup = 1'b0;
		end
		if (st_r.startup && yel.hold_b) begin
			st_nxt.factory   = 1'b1;
			st_nxt.node_addr = ADDR_RST;
			st_nxt.addr_sel  = ADDR_RST;
		end

		// operating modes
		if (gear.level && (st_r.mode != ST_GEAR)) begin
			st_nxt.mode = ST_GEAR;
		end else begin
			case (st_r.mode)
				ST_RUN: begin
					if (!st_r.startup && yel.hold_a) begin
						st_nxt.mode     = ST_ADDR;
						st_nxt.addr_sel = st_r.node_addr;
					end else if (grn.press) begin
						st_nxt.mode = ST_ADAPT;
					end
				end
				ST_ADDR: begin
					if (yel.hold_a) begin
						st_nxt.mode = ST_RUN;
					end else if (grn.press) begin
						st_nxt.node_addr = st_r.addr_sel;
						st_nxt.mode      = ST_RUN;
					end else if (yel.press) begin
						st_nxt.addr_sel = (st_r.addr_sel == ADDR_LAST) ? ADDR_FIRST :
							st_r.addr_sel + 5'h01;
					end
				end
				ST_ADAPT: begin
					if (i_motion_done) begin
						st_nxt.mode = ST_RUN;
					end
				end
				ST_GEAR: begin
					if (gear.release_evt) begin
						st_nxt.mode = ST_SYNC;
					end
				end
				ST_SYNC: begin
					if (i_motion_done) begin
						st_nxt.mode = ST_RUN;
					end
				end
				default: st_nxt.mode = ST_RUN;
			endcase
		end

		// direction switch, synchronised
		st_nxt.dir_s1 = i_dir_switch;
		st_nxt.dir_s2 = st_r.dir_s1;

		// green lamp: address pulses, then four steps dark
		if (st_r.mode != ST_ADDR) begin
			st_nxt.flash_tmr = 32'h0000_0000;
			st_nxt.flash_ph  = 6'h00;
		end else if (st_r.flash_tmr != FLASH_STEP - 32'h0000_0001) begin
			st_nxt.flash_tmr = st_r.flash_tmr + 32'h0000_0001;
		end else begin
			st_nxt.flash_tmr = 32'h0000_0000;
			st_nxt.flash_ph  = (st_r.flash_ph >= {st_r.addr_sel, 1'b0} + 6'h03) ? 6'h00 :
				st_r.flash_ph + 6'h01;
		end
		if (st_r.faults != 8'h00) begin
			st_nxt.led_green = 1'b0;
		end else if (st_r.mode == ST_ADDR) begin
			st_nxt.led_green = (st_nxt.flash_ph < {st_r.addr_sel, 1'b0}) && !st_nxt.flash_ph[0];
		end else begin
			st_nxt.led_green = 1'b1;
		end

		// yellow lamp: adaptation, synchronisation or address mode, else flicker on recent bus traffic
		if (i_reg_wr || i_reg_rd) begin
			st_nxt.bus_tmr = BUS_ACTIVE;
		end else if (st_r.bus_tmr != 32'h0000_0000) begin
			st_nxt.bus_tmr = st_r.bus_tmr - 32'h0000_0001;
		end
		if (st_r.flick_tmr != FLICKER_STEP - 32'h0000_0001) begin
			st_nxt.flick_tmr = st_r.flick_tmr + 32'h0000_0001;
		end else begin
			st_nxt.flick_tmr = 32'h0000_0000;
			st_nxt.flick_on  = ~st_r.flick_on;
		end
		if ((st_nxt.mode == ST_ADAPT) || (st_nxt.mode == ST_SYNC) || (st_nxt.mode == ST_ADDR)) begin
			st_nxt.led_yellow = 1'b1;
		end else begin
			st_nxt.led_yellow = (st_r.bus_tmr != 32'h0000_0000) && st_r.flick_on;
		end
		// motion levels registered from the next mode, so the outputs come from flops
		st_nxt.run_flags = {(st_nxt.mode == ST_GEAR), (st_nxt.mode == ST_ADAPT), (st_nxt.mode == ST_SYNC)};
	end

	// state register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r           <= '0;
			st_r.mode      <= ST_RUN;
			st_r.min_lim   <= MIN_LIM_RST;
			st_r.max_lim   <= MAX_LIM_RST;
			st_r.sensor    <= SENSOR_RST[2:0];
			st_r.busfail   <= BUSFAIL_RST;
			st_r.addr_sel  <= ADDR_RST;
			st_r.node_addr <= ADDR_RST;
			st_r.startup   <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign o_reg_ack       = st_r.ack;
	assign o_reg_rdata     = st_r.rdata;
	assign o_min_limit     = st_r.min_lim;
	assign o_max_limit     = st_r.max_lim;
	assign o_sensor_type   = st_r.sensor;
	assign o_node_addr     = st_r.node_addr;
	assign o_factory_reset = st_r.factory;
	assign o_fail_close    = st_r.fail_close;
	assign o_fail_open     = st_r.fail_open;
	assign o_motor_stop    = st_r.run_flags[2];
	assign o_adapt_run     = st_r.run_flags[1];
	assign o_sync_run      = st_r.run_flags[0];
	assign o_dir_reverse   = st_r.dir_s2;
	assign o_led_green     = st_r.led_green;
	assign o_led_yellow    = st_r.led_yellow;

endmodule : actuator_status_and_bus_watchdog

/* tb/actuator_status_and_bus_watchdog_monitor.sv */
// port checks of the actuator status and watchdog block
// assumes one clock domain and the async high reset of the block
`timescale 1ns/1ps
module actuator_status_and_bus_watchdog_monitor (
	// clock and reset
	input wire logic               i_clk,
	input wire logic               i_rst,
	// register access
	input wire logic               i_reg_wr,
	input wire logic               i_reg_rd,
	input wire act_pkg::reg_word_t i_reg_addr,
	input wire act_pkg::reg_word_t i_reg_wdata,
	input wire logic               o_reg_ack,
	input wire act_pkg::reg_word_t o_reg_rdata,
	// pins and outputs
	input wire logic               i_btn_gear,
	input wire logic               i_dir_switch,
	input wire act_pkg::reg_word_t o_min_limit,
	input wire act_pkg::reg_word_t o_max_limit,
	input wire logic [2:0]         o_sensor_type,
	input wire logic               o_fail_close,
	input wire logic               o_fail_open,
	input wire logic               o_motor_stop,
	input wire logic               o_dir_reverse,
	input wire logic               o_factory_reset
);
	import act_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// register bus answers
	a_ack_cause: assert property (
		o_reg_ack |-> $past(i_reg_wr || i_reg_rd)) else $error("ack without strobe");
	a_ack_mapped: assert property (
		i_reg_rd && i_reg_addr inside {[16'h0069:16'h006D]} |=> o_reg_ack) else $error("read not acked");
	a_status_unused: assert property (
		o_reg_ack && $past(i_reg_rd && i_reg_addr == 16'h0069) |-> (o_reg_rdata & 16'hF808) == 16'h0000)
		else $error("unused status bit set");
	// settings and their ranges
	a_min_write: assert property (
		i_reg_wr && i_reg_addr == 16'h006A && i_reg_wdata <= 16'h2710 |=> o_min_limit == $past(i_reg_wdata))
		else $error("min limit not taken");
	a_max_reject: assert property (
		i_reg_wr && i_reg_addr == 16'h006B && (i_reg_wdata < 16'h07D0 || i_reg_wdata > 16'h2710)
		|=> $stable(o_max_limit)) else $error("bad max limit taken");
	a_sensor_range: assert property (
		o_sensor_type <= 3'h4) else $error("sensor code out of range");
	// motion and factory reset outputs
	a_fail_excl: assert property (
		!(o_fail_close && o_fail_open)) else $error("close and open together");
	a_gear_stop: assert property (
		i_btn_gear [*8] |-> o_motor_stop) else $error("motor runs with gear released");
	a_dir_follow: assert property (
		i_dir_switch [*5] |-> o_dir_reverse) else $error("direction not reversed");
	a_factory_pulse: assert property (
		o_factory_reset |=> !o_factory_reset) else $error("factory pulse too long");
endmodule : actuator_status_and_bus_watchdog_monitor
bind actuator_status_and_bus_watchdog actuator_status_and_bus_watchdog_monitor mon (
	.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata), .o_reg_ack(o_reg_ack), .o_reg_rdata(o_reg_rdata), .i_btn_gear(i_btn_gear),
	.i_dir_switch(i_dir_switch), .o_min_limit(o_min_limit), .o_max_limit(o_max_limit),
	.o_sensor_type(o_sensor_type), .o_fail_close(o_fail_close), .o_fail_open(o_fail_open),
	.o_motor_stop(o_motor_stop), .o_dir_reverse(o_dir_reverse), .o_factory_reset(o_factory_reset));

/* tb/modbus_master_model.sv */
// field-bus master issuing decoded one-cycle register strobes
// assumes answers are registered on the taking edge and read just after it
`timescale 1ns/1ps
module modbus_master_model (
	// clock
	input wire logic                i_clk,
	// requests
	output logic                    o_reg_wr,
	output logic                    o_reg_rd,
	output act_pkg::reg_word_t      o_reg_addr,
	output act_pkg::reg_word_t      o_reg_wdata,
	// answers
	input wire logic                i_reg_ack,
	input wire act_pkg::reg_word_t  i_reg_rdata
);
	import act_pkg::*;
	// idle bus
	initial begin
		o_reg_wr    = 1'b0;
		o_reg_rd    = 1'b0;
		o_reg_addr  = 16'h0000;
		o_reg_wdata = 16'h0000;
	end
	// one access; the setpoint rewrites of a supervised bus use it too
	task automatic access(input logic w, input reg_word_t a, input reg_word_t d, output logic k, output reg_word_t q);
		@(posedge i_clk);
		#1;
		o_reg_wr    = w;
		o_reg_rd    = ~w;
		o_reg_addr  = a;
		o_reg_wdata = d;
		@(posedge i_clk);
		#1;
		o_reg_wr    = 1'b0;
		o_reg_rd    = 1'b0;
		o_reg_addr  = ~a; // released lines show no stale value
		o_reg_wdata = ~d;
		k           = i_reg_ack;
		q           = i_reg_rdata;
	endtask : access
endmodule : modbus_master_model

/* tb/actuator_status_and_bus_watchdog_bench.sv */
// self-checking bench for the actuator status and watchdog block
// assumes the master model and shortened hold and timeout counts
`timescale 1ns/1ps
module actuator_status_and_bus_watchdog_bench;
	import act_pkg::*;
	logic clk, rst, wr, rd, ack, done, by, bg, bgr, dir, fr, fc, fo, ms, ad, sy, dr, lg, ly;
	logic [7:0] evt;
	logic [2:0] sens;
	node_addr_t nad;
	reg_word_t addr, wdata, rdata, min_l, max_l, mn, mx, sn, bf, st, svc;
	int mismatches, check_count, seed, fr_cnt, hi;
	reg_word_t tv [8] = '{16'h07CF, 16'h07D0, 16'h2710, 16'h2711, 16'h0004, 16'h0005, 16'h0002, 16'h0000};
	modbus_master_model m (.i_clk(clk), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wdata),
		.i_reg_ack(ack), .i_reg_rdata(rdata));
	actuator_status_and_bus_watchdog #(.WDOG_TIMEOUT(40'hC8), .ADDR_HOLD(32'h32), .FACT_HOLD(32'h64),
		.FLASH_STEP(32'h4), .FLICKER_STEP(32'h2)) uut (
		.i_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.o_reg_ack(ack), .o_reg_rdata(rdata), .i_fault_evt(evt), .i_motion_done(done), .i_btn_yellow(by),
		.i_btn_green(bg), .i_btn_gear(bgr), .i_dir_switch(dir), .o_min_limit(min_l), .o_max_limit(max_l),
		.o_sensor_type(sens), .o_node_addr(nad), .o_factory_reset(fr), .o_fail_close(fc), .o_fail_open(fo),
		.o_motor_stop(ms), .o_adapt_run(ad), .o_sync_run(sy), .o_dir_reverse(dr), .o_led_green(lg),
		.o_led_yellow(ly));
	// clock and factory pulse counter
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (fr === 1'b1) fr_cnt++;
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input reg_word_t seen, input reg_word_t exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t ns: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	function automatic logic ack_exp(reg_word_t a, logic w);
		return (a >= 16'h0069 && a <= 16'h006D) || (w && a == 16'h0003);
	endfunction : ack_exp
	// write with reference model update
	task automatic wreg(input reg_word_t a, input reg_word_t d);
		logic k;
		reg_word_t q;
		m.access(1'b1, a, d, k, q);
		chk(16'(k), 16'(ack_exp(a, 1'b1)));
		if (a == 16'h006A && d <= 16'd10000) mn = d;
		if (a == 16'h006B && d >= 16'd2000 && d <= 16'd10000) mx = d;
		if (a == 16'h006C && d <= 16'd4) sn = d;
		if (a == 16'h006D && d <= 16'd2) bf = d;
		if (a == 16'h0003 && d == 16'd4) st = st & ~16'h04EE;
	endtask : wreg
	task automatic rreg(input reg_word_t a);
		logic k;
		reg_word_t q, e;
		e = (a == 16'h0069) ? (st | svc) : (a == 16'h006A) ? mn : (a == 16'h006B) ? mx : (a == 16'h006C) ? sn : bf;
		m.access(1'b0, a, 16'h0000, k, q);
		chk(16'(k), 16'(ack_exp(a, 1'b0)));
		if (k === 1'b1) chk(q, e);
	endtask : rreg
	task automatic pulse(input int which, input int n);
		if (which == 0) by = 1'b1; else if (which == 1) bg = 1'b1; else done = 1'b1;
		cyc(n);
		by = 1'b0;
		bg = 1'b0;
		done = 1'b0;
		cyc(6);
	endtask : pulse
	// watchdog against a hang
	initial begin
		#200_000;
		mismatches++;
		stop_test();
	end
	// main sequence
	initial begin
		{rst, done, by, bg, bgr, dir, evt} = {1'b1, 13'h0000};
		{mn, mx, sn, bf, st, svc} = {16'h0000, 16'h2710, 64'h0};
		seed = 28412;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		cyc(2);
		for (int a = 16'h0069; a <= 16'h0070; a++) rreg(16'(a));
		chk(16'(lg), 16'h0001);
		wreg(16'h0069, 16'hFFFF);
		for (int a = 16'h006A; a <= 16'h006D; a++) for (int i = 0; i < 8; i++) begin
			wreg(16'(a), tv[i]);
			rreg(16'(a));
		end
		for (int k = 0; k <= 4; k++) begin
			wreg(16'h006C, 16'(k));
			chk(16'(sens), 16'(k));
		end
		repeat (12) wreg(16'h006A + 16'($unsigned($random(seed)) % 3), 16'($random(seed)) & 16'h3FFF);
		chk(min_l, mn);
		chk(max_l, mx);
		for (int k = 0; k < 3; k++) begin
			wreg(16'h006D, 16'(k));
			wreg(16'h0001, 16'h1388);
			cyc(150);
			chk(16'({fo, fc}), 16'h0000);
			cyc(60);
			chk(16'({fo, fc}), 16'(k));
			if (k != 0) st[10] = 1'b1;
			rreg(16'h0069);
			wreg(16'h0002, 16'h0000);
			cyc(2);
			chk(16'({fo, fc}), 16'h0000);
			rreg(16'h0069);
			wreg(16'h0003, 16'h0004);
			rreg(16'h0069);
		end
		wreg(16'h006D, 16'h0000);
		bgr = 1'b1;
		cyc(10);
		svc = 16'h0200;
		chk(16'(ms), 16'h0001);
		rreg(16'h0069);
		bgr = 1'b0;
		cyc(10);
		svc = 16'h0100;
		chk(16'({sy, ms, ly}), 16'h0005);
		rreg(16'h0069);
		pulse(2, 1);
		svc = 16'h0000;
		chk(16'(sy), 16'h0000);
		pulse(1, 8);
		chk(16'(ad), 16'h0001);
		pulse(2, 1);
		chk(16'(ad), 16'h0000);
		pulse(0, 60);
		chk(16'(ly), 16'h0001);
		pulse(0, 6);
		pulse(0, 6);
		hi = 0;
		repeat (56) begin
			cyc(1);
			hi += int'(lg === 1'b1);
		end
		chk(16'(hi > 0 && hi < 56), 16'h0001);
		pulse(1, 6);
		chk(16'(nad), 16'h0003);
		hi = 0;
		repeat (8) begin
			cyc(1);
			hi += int'(ly === 1'b1);
		end
		chk(16'(hi), 16'h0004);
		dir = 1'b1;
		cyc(6);
		chk(16'(dr), 16'h0001);
		evt = 8'hFF;
		cyc(1);
		evt = 8'($random(seed));
		cyc(1);
		evt = 8'h00;
		cyc(2);
		st = st | 16'h00F7;
		chk(16'(lg), 16'h0000);
		rreg(16'h0069);
		wreg(16'h0003, 16'h0004);
		rreg(16'h0069);
		hi = fr_cnt;
		by = 1'b1;
		rst = 1'b1; // restart with the yellow button held for the factory reset hold
		cyc(2);
		rst = 1'b0;
		{mn, mx, sn, bf, st} = {16'h0000, 16'h2710, 48'h0};
		cyc(110);
		chk(16'(ly), 16'h0000);
		by = 1'b0;
		cyc(6);
		chk(16'(fr_cnt - hi), 16'h0001);
		chk(16'(nad), 16'h0001);
		rreg(16'h006C);
		stop_test();
	end
endmodule : actuator_status_and_bus_watchdog_bench
